// *** rtl/adc_result_slot.sv ***
`timescale 1ns/100ps
module adc_result_slot
  import adc_status_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_data,
  input  wire logic        conv_over,
  input  wire logic        conv_under,
  input  wire logic        chan_en,
  input  wire logic        powered_down,
  input  wire logic        rdy_clear,
  input  wire logic        cal_done,
  output logic      [15:0] clamped,
  output logic      [15:0] result,
  output logic             err_flag,
  output logic             rdy_flag
);

  logic [15:0] result_reg;
  logic [15:0] result_next;
  logic        err_reg;
  logic        err_next;
  logic        rdy_reg;
  logic        rdy_next;
  wire         conv_ok;
  wire         bad;
  wire         store;
  wire         err_set;
  wire         rdy_set;

  ////////////////////////////////////////////////////////////////////////////
  assign conv_ok = conv_done & chan_en;
  assign bad     = conv_over | conv_under;
  // hold result
  // Unread data is kept unless the core sleeps
  assign store   = conv_ok & (~rdy_reg | powered_down);
  assign clamped = conv_under ? NEG_FS : (conv_over ? POS_FS : conv_data);
  assign result_next = store ? clamped : result_reg;
  assign err_set  = conv_ok & bad;
  assign err_next = err_set | (err_reg & ~(store & ~bad));
  assign rdy_set  = (store & ~bad) | cal_done;
  assign rdy_next = rdy_set | (rdy_reg & ~rdy_clear);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= WORD_RST;
      err_reg    <= 1'b0;
      rdy_reg    <= 1'b0;
    end else begin
      result_reg <= result_next;
      err_reg    <= err_next;
      rdy_reg    <= rdy_next;
    end
  end

  assign result   = result_reg;
  assign err_flag = err_reg;
  assign rdy_flag = rdy_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_err_set: assert property (conv_done && chan_en && (conv_over || conv_under)
    |=> err_flag) else $error("error flag not set");
  a_clamp_under: assert property (store && conv_under
    |=> result == 16'h8000) else $error("underrange not clamped");
  a_err_clear: assert property (store && !conv_over && !conv_under
    |=> !err_flag) else $error("error flag not cleared");
  a_result_hold: assert property (rdy_flag && !powered_down
    |=> $stable(result)) else $error("unread result overwritten");
  a_rdy_set: assert property (store && !conv_over && !conv_under
    |=> rdy_flag) else $error("ready flag not set");
  a_rdy_clear: assert property (rdy_clear && !cal_done && !conv_done
    |=> !rdy_flag) else $error("ready flag not cleared");

endmodule : adc_result_slot

// *** rtl/adc_status_flag_logic.sv ***
// Overview of operation
// - Status register is sixteen bits, read only, zero after reset.
// - Bit 15 sets when a calibration cycle finishes.
// - Writing the mode register clears bit 15.
// - Bit 14 sets on temperature overrange or underrange.
// - Error results are clamped to negative or positive full scale.
// - Storing an in-range temperature result clears bit 14.
// - Bit 13 sets on voltage overrange or underrange.
// - Storing an in-range voltage result clears bit 13.
// - Bit 12 sets on current overrange or underrange.
// - Storing an in-range current result clears bit 12.
// - With comparator on, bit 4 sets when current magnitude exceeds threshold.
// - With counter on, bit 4 sets once the count reaches the limit.
// - Mode write or comparator disable clears bit 4.
// - Bit 3 sets from the overrange detector, sampled every 125 us.
// - Bit 3 clears only on detect disable or current gain change.
// - Bit 2 sets on stored valid temperature result or calibration end.
// - Reading temperature or current result clears bit 2.
// - Bit 1 sets on stored valid voltage result or calibration end.
// - Reading voltage or current result clears bit 1.
// - Bit 0 sets on stored valid current result or calibration end.
// - Reading the current result clears bit 0.
// - Low eight status bits are ORed into one interrupt.
// - Each low bit reaches the interrupt only when unmasked; reset masks all.
// - Current channel off, voltage or temperature read clears both voltage and temperature ready.
// - A result is not overwritten until its ready flag clears, unless the core is powered down.
//
// Added by the designer: register access over APB.
`timescale 1ns/100ps
module adc_status_flag_logic
  import adc_status_pkg::*;
#(
  parameter int unsigned OVR_TICK = OVR_TICK_CYCLES
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [NUM_CHAN-1:0]  conv_done,
  input  wire logic [NUM_CHAN-1:0][15:0] conv_data,
  input  wire logic [NUM_CHAN-1:0]  conv_over,
  input  wire logic [NUM_CHAN-1:0]  conv_under,
  input  wire logic                 cal_done,
  input  wire logic                 cur_overrange_in,
  input  wire logic                 core_powered_down,
  output logic                      adc_irq,
  output logic      [7:0]           adc_mode,
  output logic      [7:0]           adc_config,
  output logic      [15:0]          current_control
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic        pready_reg;
  logic        pslverr_reg;
  logic        pslverr_next;
  wire         setup;
  wire         acc;
  wire         wr;
  wire         rd;
  wire         sel_status;
  wire         sel_mask;
  wire         sel_mode;
  wire         sel_cur_res;
  wire         sel_volt_res;
  wire         sel_temp_res;
  wire         sel_ctrl;
  wire         sel_cfg;
  wire         sel_thr;
  wire         sel_tcl;
  wire         sel_thv;
  wire         sel_chen;
  wire         mapped;

  assign setup        = psel & ~penable;
  assign acc          = psel & penable & pready_reg;
  assign wr           = acc & pwrite;
  assign rd           = acc & ~pwrite;
  assign sel_status   = (paddr == ADDR_STATUS);
  assign sel_mask     = (paddr == ADDR_MASK);
  assign sel_mode     = (paddr == ADDR_MODE);
  assign sel_cur_res  = (paddr == ADDR_CUR_RES);
  assign sel_volt_res = (paddr == ADDR_VOLT_RES);
  assign sel_temp_res = (paddr == ADDR_TEMP_RES);
  assign sel_ctrl     = (paddr == ADDR_CUR_CTRL);
  assign sel_cfg      = (paddr == ADDR_CONFIG);
  assign sel_thr      = (paddr == ADDR_THRESHOLD);
  assign sel_tcl      = (paddr == ADDR_THR_LIMIT);
  assign sel_thv      = (paddr == ADDR_THR_COUNT);
  assign sel_chen     = (paddr == ADDR_CHAN_EN);
  assign mapped       = sel_status | sel_mask | sel_mode | sel_cur_res |
                        sel_volt_res | sel_temp_res | sel_ctrl | sel_cfg |
                        sel_thr | sel_tcl | sel_thv | sel_chen;

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  logic [7:0]  mask_reg;
  logic [7:0]  mode_reg;
  logic [7:0]  cfg_reg;
  logic [15:0] ctrl_reg;
  logic [15:0] thr_reg;
  logic [15:0] tcl_reg;
  logic [2:0]  chen_reg;
  wire         mode_wr;
  wire         gain_chg;

  assign mode_wr  = wr & sel_mode;
  assign gain_chg = wr & sel_ctrl &
                    (pwdata[GAIN_LSB +: GAIN_W] != ctrl_reg[GAIN_LSB +: GAIN_W]);

  // status has no write path
  // Writes to the status word complete without effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= MASK_RST;
      mode_reg <= MODE_RST;
      cfg_reg  <= CFG_RST;
      ctrl_reg <= CTRL_RST;
      thr_reg  <= WORD_RST;
      tcl_reg  <= WORD_RST;
      chen_reg <= CHEN_RST;
    end else if (wr) begin
      if (sel_mask) mask_reg <= pwdata[7:0];
      if (sel_mode) mode_reg <= pwdata[7:0];
      if (sel_cfg)  cfg_reg  <= pwdata[7:0];
      if (sel_ctrl) ctrl_reg <= pwdata[15:0];
      if (sel_thr)  thr_reg  <= pwdata[15:0];
      if (sel_tcl)  tcl_reg  <= pwdata[15:0];
      if (sel_chen) chen_reg <= pwdata[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel result slots
  logic [NUM_CHAN-1:0][15:0] clamped;
  logic [NUM_CHAN-1:0][15:0] result;
  logic [NUM_CHAN-1:0]       err_flag;
  logic [NUM_CHAN-1:0]       rdy_flag;
  logic [NUM_CHAN-1:0]       rdy_clear;
  wire                       rd_cur;
  wire                       rd_volt;
  wire                       rd_temp;
  wire                       cur_off;

  assign rd_cur  = rd & sel_cur_res;
  assign rd_volt = rd & sel_volt_res;
  assign rd_temp = rd & sel_temp_res;
  assign cur_off = ~chen_reg[CHAN_CUR];
  assign rdy_clear[CHAN_CUR]  = rd_cur;
  assign rdy_clear[CHAN_VOLT] = rd_cur | rd_volt | (cur_off & rd_temp);
  assign rdy_clear[CHAN_TEMP] = rd_cur | rd_temp | (cur_off & rd_volt);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++) begin : g_chan
      adc_result_slot u_slot (
        .pclk         (pclk),
        .presetn      (presetn),
        .conv_done    (conv_done[gi]),
        .conv_data    (conv_data[gi]),
        .conv_over    (conv_over[gi]),
        .conv_under   (conv_under[gi]),
        .chan_en      (chen_reg[gi]),
        .powered_down (core_powered_down),
        .rdy_clear    (rdy_clear[gi]),
        .cal_done     (cal_done),
        .clamped      (clamped[gi]),
        .result       (result[gi]),
        .err_flag     (err_flag[gi]),
        .rdy_flag     (rdy_flag[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Calibration flag
  logic cal_reg;
  wire  cal_next;
  assign cal_next = cal_done | (cal_reg & ~mode_wr);

  ////////////////////////////////////////////////////////////////////////////
  // Comparator and threshold counter
  logic [15:0] thv_reg;
  logic [15:0] thv_next;
  logic        cmp_reg;
  wire         cmp_next;
  wire [15:0]  cur_mag;
  wire         cmp_event;
  wire         exceed;
  wire [15:0]  cnt_inc;
  wire         cmp_set;

  assign cur_mag   = clamped[CHAN_CUR][15] ?
                     (~clamped[CHAN_CUR] + 16'h0001) : clamped[CHAN_CUR];
  assign cmp_event = conv_done[CHAN_CUR] & chen_reg[CHAN_CUR] &
                     cfg_reg[CFG_CMP_EN];
  assign exceed    = cur_mag > thr_reg;
  // Saturates so a long run never wraps back below the limit
  assign cnt_inc   = (thv_reg == CNT_MAX) ? thv_reg : (thv_reg + 16'h0001);
  assign thv_next  = (~cfg_reg[CFG_CMP_EN] | mode_wr) ? WORD_RST :
                     (cmp_event ? (exceed ? cnt_inc : WORD_RST) : thv_reg);
  assign cmp_set   = cmp_event & exceed &
                     (~cfg_reg[CFG_TCNT_EN] | (cnt_inc == tcl_reg));
  assign cmp_next  = cmp_set | (cmp_reg & ~mode_wr & cfg_reg[CFG_CMP_EN]);

  ////////////////////////////////////////////////////////////////////////////
  // Overrange sampling
  logic [OVR_CNT_W-1:0] tick_cnt_reg;
  logic [OVR_CNT_W-1:0] tick_cnt_next;
  logic                 ovr_reg;
  wire                  ovr_tick;
  wire                  ovr_set;
  wire                  ovr_next;

  assign ovr_tick      = (tick_cnt_reg == OVR_CNT_W'(OVR_TICK - 1));
  assign tick_cnt_next = ovr_tick ? '0 : (tick_cnt_reg + 1'b1);
  assign ovr_set       = ovr_tick & cfg_reg[CFG_OVR_EN] & cur_overrange_in;
  // cleared by disable or gain change
  assign ovr_next      = ovr_set | (ovr_reg & cfg_reg[CFG_OVR_EN] & ~gain_chg);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_reg      <= 1'b0;
      thv_reg      <= WORD_RST;
      cmp_reg      <= 1'b0;
      tick_cnt_reg <= '0;
      ovr_reg      <= 1'b0;
    end else begin
      cal_reg      <= cal_next;
      thv_reg      <= thv_next;
      cmp_reg      <= cmp_next;
      tick_cnt_reg <= tick_cnt_next;
      ovr_reg      <= ovr_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word, interrupt and read mux
  wire [15:0] status_word;
  wire        irq_next;

  assign status_word = {cal_reg, err_flag[CHAN_TEMP], err_flag[CHAN_VOLT],
                        err_flag[CHAN_CUR], 7'h00, cmp_reg, ovr_reg,
                        rdy_flag[CHAN_TEMP], rdy_flag[CHAN_VOLT],
                        rdy_flag[CHAN_CUR]};
  assign irq_next = |(status_word[ST_IRQ_W-1:0] & mask_reg);

  // Read data sampled in setup so every bus output is a flop
  assign prdata_next =
    sel_status   ? {16'h0000, status_word}        :
    sel_mask     ? {24'h000000, mask_reg}         :
    sel_mode     ? {24'h000000, mode_reg}         :
    sel_cur_res  ? {16'h0000, result[CHAN_CUR]}   :
    sel_volt_res ? {16'h0000, result[CHAN_VOLT]}  :
    sel_temp_res ? {16'h0000, result[CHAN_TEMP]}  :
    sel_ctrl     ? {16'h0000, ctrl_reg}           :
    sel_cfg      ? {24'h000000, cfg_reg}          :
    sel_thr      ? {16'h0000, thr_reg}            :
    sel_tcl      ? {16'h0000, tcl_reg}            :
    sel_thv      ? {16'h0000, thv_reg}            :
    sel_chen     ? {29'h0000000, chen_reg}        : 32'h00000000;
  assign pslverr_next = ~mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      adc_irq     <= 1'b0;
    end else begin
      pready_reg  <= setup;
      adc_irq     <= irq_next;
      // Error flop lives only in the access cycle, like pready
      pslverr_reg <= setup & pslverr_next;
      if (setup) begin
        prdata_reg  <= pwrite ? 32'h00000000 : prdata_next;
      end
    end
  end

  assign prdata          = prdata_reg;
  assign pready          = pready_reg;
  assign pslverr         = pslverr_reg;
  assign adc_mode        = mode_reg;
  assign adc_config      = cfg_reg;
  assign current_control = ctrl_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_cal_set: assert property (cal_done
    |=> status_word[15]) else $error("calibration flag not set");
  a_cal_clear: assert property (mode_wr && !cal_done
    |=> !status_word[15]) else $error("mode write kept cal flag");
  a_status_ro: assert property (wr && sel_status && !cal_done &&
    conv_done == 3'h0 && !ovr_tick
    |=> status_word == $past(status_word) ||
        status_word == ($past(status_word) & 16'h7FEF))
    else $error("status changed by write");
  a_cmp_disable: assert property (!cfg_reg[CFG_CMP_EN]
    |=> !status_word[4]) else $error("comparator flag kept");
  a_cmp_count: assert property (cmp_event && exceed && cfg_reg[CFG_TCNT_EN] &&
    cnt_inc != tcl_reg && !status_word[4] && !mode_wr
    |=> !status_word[4]) else $error("comparator set early");
  a_ovr_disable: assert property (!cfg_reg[CFG_OVR_EN]
    |=> !status_word[3]) else $error("overrange flag kept");
  a_ovr_hold: assert property (status_word[3] && cfg_reg[CFG_OVR_EN] &&
    !gain_chg |=> status_word[3]) else $error("overrange lost");
  a_irq_masked: assert property (mask_reg == 8'h00 && $past(mask_reg) == 8'h00
    |-> !adc_irq) else $error("masked interrupt raised");
  a_irq_high: assert property ((status_word[7:0] & mask_reg) != 8'h00
    |=> adc_irq) else $error("interrupt missing");
  a_cur_read: assert property (rd_cur && !cal_done
    |=> !status_word[2] && !status_word[1]) else $error("ready kept");
  a_cur_off_read: assert property (rd_volt && !chen_reg[CHAN_CUR] &&
    !cal_done && conv_done == 3'h0
    |=> !status_word[2]) else $error("temp ready kept");
  a_pready_one: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");

endmodule : adc_status_flag_logic

// *** rtl/adc_status_pkg.sv ***
package adc_status_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte addresses
  localparam logic [31:0] ADDR_STATUS     = 32'hFFFF0500;
  localparam logic [31:0] ADDR_MASK       = 32'hFFFF0504;
  localparam logic [31:0] ADDR_MODE       = 32'hFFFF0508;
  localparam logic [31:0] ADDR_CUR_RES    = 32'hFFFF050C;
  localparam logic [31:0] ADDR_VOLT_RES   = 32'hFFFF0510;
  localparam logic [31:0] ADDR_TEMP_RES   = 32'hFFFF0514;
  localparam logic [31:0] ADDR_CUR_CTRL   = 32'hFFFF0518;
  localparam logic [31:0] ADDR_CONFIG     = 32'hFFFF051C;
  localparam logic [31:0] ADDR_THRESHOLD  = 32'hFFFF0520;
  localparam logic [31:0] ADDR_THR_LIMIT  = 32'hFFFF0524;
  localparam logic [31:0] ADDR_THR_COUNT  = 32'hFFFF0528;
  localparam logic [31:0] ADDR_CHAN_EN    = 32'hFFFF052C;

  ////////////////////////////////////////////////////////////////////////////
  // Channels
  localparam int NUM_CHAN  = 3;
  localparam int CHAN_CUR  = 0;
  localparam int CHAN_VOLT = 1;
  localparam int CHAN_TEMP = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Status bit positions
  localparam int ST_CAL      = 15;
  localparam int ST_ERR_BASE = 12;
  localparam int ST_CMP      = 4;
  localparam int ST_OVR      = 3;
  localparam int ST_RDY_BASE = 0;
  localparam int ST_IRQ_W    = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration bits and control fields
  localparam int CFG_OVR_EN  = 2;
  localparam int CFG_CMP_EN  = 3;
  localparam int CFG_TCNT_EN = 4;
  localparam int GAIN_LSB    = 0;
  localparam int GAIN_W      = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and codes
  localparam logic [15:0] STATUS_RST = 16'h0000;
  localparam logic [7:0]  MASK_RST   = 8'h00;
  localparam logic [7:0]  MODE_RST   = 8'h00;
  localparam logic [7:0]  CFG_RST    = 8'h00;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] WORD_RST   = 16'h0000;
  localparam logic [2:0]  CHEN_RST   = 3'h0;
  localparam logic [15:0] NEG_FS     = 16'h8000;
  localparam logic [15:0] POS_FS     = 16'h7FFF;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS   = 25;
  localparam int OVR_PERIOD_US   = 125;
  localparam int OVR_TICK_CYCLES = OVR_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int OVR_CNT_W       = 13;

endpackage : adc_status_pkg

// *** tb/adc_status_flag_logic_test.sv ***
`timescale 1ns/100ps
`define CHK(gv, ev) begin \
  checks_done++; \
  if ((gv) !== (ev)) begin \
    fail_count++; \
    $display("mismatch t=%0t got %h exp %h", $time, gv, ev); \
  end \
end
module adc_status_flag_logic_test;
  import adc_status_pkg::*;
  logic                      pclk, presetn, psel, penable, pwrite;
  logic                      pready, pslverr, adc_irq, e, cal_done;
  logic                      cur_overrange_in, core_powered_down;
  logic [31:0]               paddr, pwdata, prdata, q;
  logic [NUM_CHAN-1:0]       conv_done, conv_over, conv_under;
  logic [NUM_CHAN-1:0][15:0] conv_data;
  logic [15:0]               d;
  logic [7:0]                adc_mode, adc_config;
  logic [15:0]               current_control;
  int                        seed = 5;
  int                        fail_count = 0;
  int                        checks_done = 0;

  apb_core_model u_cpu (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // Short overrange tick keeps the run brief
  adc_status_flag_logic #(.OVR_TICK(16)) u_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_done(conv_done), .conv_data(conv_data),
    .conv_over(conv_over), .conv_under(conv_under), .cal_done(cal_done),
    .cur_overrange_in(cur_overrange_in),
    .core_powered_down(core_powered_down), .adc_irq(adc_irq),
    .adc_mode(adc_mode), .adc_config(adc_config),
    .current_control(current_control));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] bitv(input int b);
    return 16'h0001 << b;
  endfunction : bitv

  function automatic logic [15:0] exp_clamp(input logic ov);
    return ov ? POS_FS : NEG_FS;
  endfunction : exp_clamp

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] v);
    u_cpu.xfer(w, a, v, q, e);
    if (u_cpu.hang_count != 0) begin
      fail_count++;
      final_report();
    end
  endtask : bus

  task automatic st(input logic [15:0] ev);
    bus(1'b0, ADDR_STATUS, 32'h0);
    `CHK(q[15:0] & 16'hF81F, ev & 16'hF81F)
  endtask : st

  task automatic stb(input int b, input logic v);
    bus(1'b0, ADDR_STATUS, 32'h0);
    `CHK(q[b], v)
  endtask : stb

  task automatic conv(input int ch, input logic [15:0] dv,
                      input logic ov, input logic un);
    @(posedge pclk);
    conv_done[ch] <= 1'b1;
    conv_data[ch] <= dv;
    conv_over[ch] <= ov;
    conv_under[ch] <= un;
    @(posedge pclk);
    conv_done <= '0;
    conv_over <= '0;
    conv_under <= '0;
  endtask : conv

  task automatic cal();
    @(posedge pclk);
    cal_done <= 1'b1;
    @(posedge pclk);
    cal_done <= 1'b0;
  endtask : cal

  // Irq is registered one cycle behind status
  task automatic irq_is(input logic v);
    repeat (3) @(posedge pclk);
    #1;
    `CHK(adc_irq, v)
  endtask : irq_is

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {presetn, cal_done, cur_overrange_in, core_powered_down} = 4'h0;
    {conv_done, conv_over, conv_under} = '0;
    conv_data = '0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    st(16'h0000);
    bus(1'b0, ADDR_MASK, 32'h0);
    `CHK(q, 32'h0)
    bus(1'b1, ADDR_STATUS, 32'hFFFF);
    st(16'h0000);
    bus(1'b0, 32'hFFFF0600, 32'h0);
    `CHK({e, q}, 33'h100000000)
    $display("reset test done");
    cal();
    st(16'h8007);
    bus(1'b1, ADDR_MODE, 32'h5A);
    st(16'h0007);
    `CHK(adc_mode, 8'h5A)
    bus(1'b0, ADDR_CUR_RES, 32'h0);
    st(16'h0000);
    $display("calibration test done");
    bus(1'b1, ADDR_CHAN_EN, 32'h7);
    for (int ch = 0; ch < NUM_CHAN; ch++) begin
      d = 16'($random(seed));
      conv(ch, d, 1'b0, 1'b0);
      st(bitv(ST_RDY_BASE + ch));
      bus(1'b0, ADDR_CUR_RES + 32'(4 * ch), 32'h0);
      `CHK(q, {16'h0000, d})
      st(16'h0000);
    end
    for (int k = 0; k < 6; k++) begin
      conv(k % 3, 16'($random(seed)), k < 3, k >= 3);
      st(bitv(ST_ERR_BASE + k % 3));
      bus(1'b0, ADDR_CUR_RES + 32'(4 * (k % 3)), 32'h0);
      `CHK(q[15:0], exp_clamp(k < 3))
      conv(k % 3, 16'h1234, 1'b0, 1'b0);
      st(bitv(k % 3));
      bus(1'b0, ADDR_CUR_RES, 32'h0);
    end
    $display("conversion test done");
    d = 16'($random(seed));
    conv(0, d, 1'b0, 1'b0);
    conv(0, ~d, 1'b0, 1'b0);
    bus(1'b0, ADDR_CUR_RES, 32'h0);
    `CHK(q[15:0], d)
    conv(0, d, 1'b0, 1'b0);
    core_powered_down <= 1'b1;
    conv(0, ~d, 1'b0, 1'b0);
    bus(1'b0, ADDR_CUR_RES, 32'h0);
    `CHK(q[15:0], ~d)
    core_powered_down <= 1'b0;
    bus(1'b1, ADDR_CHAN_EN, 32'h6);
    for (int ch = 0; ch < NUM_CHAN; ch++)
      conv(ch, d, 1'b0, 1'b0);
    st(16'h0006);
    bus(1'b0, ADDR_VOLT_RES, 32'h0);
    st(16'h0000);
    bus(1'b1, ADDR_CHAN_EN, 32'h7);
    $display("overwrite test done");
    bus(1'b1, ADDR_THRESHOLD, 32'h100);
    bus(1'b1, ADDR_CONFIG, 32'h8);
    conv(0, 16'h0100, 1'b0, 1'b0);
    stb(ST_CMP, 1'b0);
    `CHK(adc_config, 8'h08)
    conv(0, 16'hFEFF, 1'b0, 1'b0);
    stb(ST_CMP, 1'b1);
    bus(1'b1, ADDR_CONFIG, 32'h0);
    stb(ST_CMP, 1'b0);
    bus(1'b1, ADDR_THR_LIMIT, 32'h3);
    bus(1'b1, ADDR_CONFIG, 32'h18);
    for (int i = 0; i < 3; i++) begin
      conv(0, 16'h7000, 1'b0, 1'b0);
      stb(ST_CMP, i == 2);
    end
    bus(1'b1, ADDR_MODE, 32'h0);
    stb(ST_CMP, 1'b0);
    $display("comparator test done");
    cur_overrange_in <= 1'b1;
    bus(1'b1, ADDR_CONFIG, 32'h4);
    repeat (20) @(posedge pclk);
    stb(ST_OVR, 1'b1);
    cur_overrange_in <= 1'b0;
    repeat (20) @(posedge pclk);
    stb(ST_OVR, 1'b1);
    bus(1'b1, ADDR_CUR_CTRL, 32'h1);
    stb(ST_OVR, 1'b0);
    `CHK(current_control, 16'h0001)
    cur_overrange_in <= 1'b1;
    repeat (20) @(posedge pclk);
    stb(ST_OVR, 1'b1);
    bus(1'b1, ADDR_CONFIG, 32'h0);
    stb(ST_OVR, 1'b0);
    cur_overrange_in <= 1'b0;
    $display("overrange test done");
    bus(1'b0, ADDR_CUR_RES, 32'h0);
    cal();
    irq_is(1'b0);
    bus(1'b1, ADDR_MASK, 32'h2);
    irq_is(1'b1);
    bus(1'b0, ADDR_CUR_RES, 32'h0);
    bus(1'b1, ADDR_MASK, 32'hFF);
    irq_is(1'b0);
    $display("interrupt test done");
    final_report();
  end
endmodule : adc_status_flag_logic_test

// *** tb/apb_core_model.sv ***
`timescale 1ns/100ps
module apb_core_model (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] paddr,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  int hang_count = 0;

  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
  end

  // Request held until pready is seen at an edge
  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    if (n >= 50)
      hang_count++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : apb_core_model
